// >>> rtl/psp_pkg.sv
// Constants and helpers for the phase share and power good config bank.
// Assumes a 100 MHz core clock and 16-bit command data words.
package psp_pkg;

  // ****************************************************************
  // Command codes and reset values
  // ****************************************************************
  localparam logic [7:0]  CMD_RAIL_CFG  = 8'hd3;
  localparam logic [7:0]  CMD_PG_DELAY  = 8'hd4;
  localparam logic [7:0]  CMD_ADV_LOOP  = 8'hd5;
  localparam logic [7:0]  CMD_INDUCTOR  = 8'hd6;
  localparam logic [15:0] RAIL_CFG_RST  = 16'h0000;
  localparam logic [15:0] PG_DELAY_RST  = 16'hba00;
  localparam logic [13:0] ADV_LOOP_RST  = 14'h2064;
  localparam logic [15:0] INDUCTOR_RST  = 16'haa66;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int PH_ID_MSB   = 15;
  localparam int PH_ID_LSB   = 13;
  localparam int RAIL_MSB    = 12;
  localparam int RAIL_LSB    = 8;
  localparam int PH_CNT_MSB  = 2;
  localparam int PH_CNT_LSB  = 0;
  localparam int GAIN_MSB    = 13;
  localparam int GAIN_LSB    = 12;
  localparam int THR_MSB     = 11;
  localparam int ADV_MSB     = 13;
  localparam int LIN_Y_SIGN  = 10;
  localparam int STRAP_W     = 7;

  // ****************************************************************
  // Limits and timing
  // ****************************************************************
  localparam int LIN_FRAC      = 10;
  localparam int PG_MAX_MS     = 125;
  localparam int IND_MAX_UH    = 100;
  localparam int PG_MAX_UNITS  = PG_MAX_MS << LIN_FRAC;
  localparam int IND_MAX_UNITS = IND_MAX_UH << LIN_FRAC;
  localparam int US_PER_MS     = 1000;
  localparam int PG_MIN_EN_MS  = 2;
  localparam int PG_MIN_EN_US  = PG_MIN_EN_MS * US_PER_MS;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEG_FULL      = 360;

  // Linear-11 value Y*2^N scaled by 2^LIN_FRAC; caller checks Y sign.
  function automatic logic [39:0] psp_lin11_scaled(input logic [15:0] v);
    logic [39:0]       m;
    logic signed [5:0] sh;
    m  = {29'h0, v[10:0]};
    sh = 6'(signed'(v[15:11])) + 6'sd10;
    if (sh >= 6'sd0)
      psp_lin11_scaled = m << sh[4:0];
    else
      psp_lin11_scaled = m >> 5'(-sh);
  endfunction

endpackage

// >>> rtl/psp_if.sv
// Carrier between the config bank top and its two helper modules.
// Assumes all ends share mclk.
`timescale 1ns/1ns
interface psp_if;
  logic        out_en;
  logic        above_on;
  logic [31:0] delay_us;
  logic        pgood;
  logic [2:0]  phase_id;
  logic [2:0]  phases_m1;
  logic [8:0]  offset_deg;

  modport ctl (output out_en, above_on, delay_us, phase_id, phases_m1,
               input pgood, offset_deg);
  modport tmr (input out_en, above_on, delay_us, output pgood);
  modport phs (input phase_id, phases_m1, output offset_deg);
endinterface

// >>> rtl/psp_pg_timer.sv
// Power good delay timer with a minimum enabled time.
// Assumes inputs synchronous to mclk; ce freezes all state.
`timescale 1ns/1ns
module psp_pg_timer
  import psp_pkg::*;
#(
  parameter int TICK_CYC  = TICK_CYCLES,
  parameter int MIN_EN_US = PG_MIN_EN_US
)(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic ce,
  psp_if.tmr        pif
);
  import psp_pkg::*;

  typedef enum logic [1:0] {
    PGT_IDLE = 2'b00,
    PGT_WAIT = 2'b01,
    PGT_GOOD = 2'b10
  } psp_pgt_state_t;

  typedef struct packed {
    psp_pgt_state_t state;
    logic [7:0]     tick;
    logic [15:0]    en_us;
    logic [31:0]    dly_us;
  } psp_pgt_t;

  psp_pgt_t q, d;
  logic     tick_hit;
  logic     en_ok;
  logic     go_ok;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Counts microsecond ticks while enabled and while above threshold.
  always_comb
  begin
    d        = q;
    tick_hit = (q.tick == 8'(TICK_CYC - 1));
    en_ok    = (q.en_us >= 16'(MIN_EN_US));          // [R9]
    go_ok    = pif.above_on && en_ok && (q.dly_us >= pif.delay_us);
    if (!pif.out_en)
      d = '0;
    else
    begin
      d.tick = tick_hit ? 8'h00 : q.tick + 8'h01;
      if (tick_hit && !en_ok)
        d.en_us = q.en_us + 16'h0001;
      case (q.state)
        PGT_IDLE:
          if (pif.above_on)
          begin
            d.state  = PGT_WAIT;
            d.dly_us = '0;
          end
        PGT_WAIT:
          if (!pif.above_on)
            d.state = PGT_IDLE;
          else if (go_ok)
            d.state = PGT_GOOD;                        // [R8]
          else if (tick_hit)
            d.dly_us = q.dly_us + 32'h1;
        PGT_GOOD:
          if (!pif.above_on)
            d.state = PGT_IDLE;
        default: d.state = PGT_IDLE;
      endcase
    end
  end

  // State register, held while ce is low.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else if (ce)
      q <= d;
  end

  assign pif.pgood = (q.state == PGT_GOOD);

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  pg_rise_cause_a: assert property ($rose(pif.pgood) |-> $past(go_ok)) // [R8]
    else $error("Power good rose before its delay ran out.");
  pg_min_en_a: assert property ($rose(pif.pgood) |-> en_ok) // [R9]
    else $error("Power good rose inside the minimum enabled time.");
  pg_drop_a: assert property (ce && !pif.above_on |=> !pif.pgood) // [R8]
    else $error("Power good stayed high below threshold.");

  // Power good that is up, with the rail enabled and above threshold,
  // must not drop on its own.
  sequence pg_up_s;
    pif.pgood;
  endsequence

  sequence pg_kept_s;
    ce && pif.out_en && pif.above_on;
  endsequence

  pg_hold_a: assert property (pg_up_s ##0 pg_kept_s |=> pif.pgood) // [R8]
    else $error("Power good dropped while the rail stayed good.");

endmodule // psp_pg_timer

// >>> rtl/psp_phase_gen.sv
// Equal phase offset for this device inside a shared rail.
// Assumes phase fields come from the config bank.
`timescale 1ns/1ns
module psp_phase_gen
  import psp_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic ce,
  psp_if.phs        pif
);
  import psp_pkg::*;

  typedef struct packed {
    logic [8:0] offset;
  } psp_phs_t;

  psp_phs_t    q, d;
  logic [8:0]  step;
  logic [11:0] prod;

  // Step is a full turn over the phase count; 7 phases truncates.
  always_comb
  begin
    d    = q;
    step = 9'(DEG_FULL / (32'(pif.phases_m1) + 1));  // [R4]
    prod = 12'(pif.phase_id) * 12'(step);
    d.offset = 9'(prod % 12'(DEG_FULL));             // [R4]
  end

  // Offset register.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else if (ce)
      q <= d;
  end

  assign pif.offset_deg = q.offset;

  // ****************************************************************
  // Checks
  // ****************************************************************
  two_phase_180_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && pif.phases_m1 == 3'd1 && pif.phase_id == 3'd1
    |=> pif.offset_deg == 9'd180) // [R4]
    else $error("Second phase of two is not at half a turn.");

endmodule // psp_phase_gen

// >>> rtl/psp_top.sv
// Phase share, power good delay, adaptive loop and inductor commands.
// Assumes a bus front end that decodes command writes and reads.
//
// Function
// [R1] Bits 15:13 hold phase position, default 0.
// [R2] Bits 12:8 hold the shared rail identifier.
// [R3] Bits 2:0 hold phase count minus one.
// [R4] Rail phases spaced equally; two means 180.
// [R5] Rail identifier loads strap address low bits.
// [R6] Host sets same rail, count, ids in order.
// [R7] Host sets same group, group messages enabled.
// [R8] Power good waits programmed delay above threshold.
// [R9] Power good may stay low before 2 ms.
// [R10] Out of range delay writes are rejected.
// [R11] Bits 13:12 pick gain divide 1,2,4,8.
// [R12] Bits 11:0 hold steady state threshold.
// [R13] Adaptive loop resets 2064h; 15:14 unused.
// [R14] Inductor over 0 to 100 uH, default AA66h.
// [R15] Delay and inductor use linear-11 format.
`timescale 1ns/1ns
module psp_top
  import psp_pkg::*;
#(
  parameter int TICK_CYC  = TICK_CYCLES,
  parameter int MIN_EN_US = PG_MIN_EN_US
)(
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire logic                    ce,
  input  wire logic [STRAP_W-1:0]      addr_strap,
  input  wire logic [7:0]              cmd_code,
  input  wire logic                    wr_en,
  input  wire logic [15:0]             wr_data,
  input  wire logic                    rd_en,
  output logic      [15:0]             rd_data_q,
  output logic                         cmd_err,
  input  wire logic                    out_enable,
  input  wire logic                    vout_above_on,
  output logic                         pgood_pin,
  output logic      [2:0]              phase_id,
  output logic      [4:0]              rail_id,
  output logic      [3:0]              phase_count,
  output logic      [8:0]              phase_offset_deg,
  output logic      [1:0]              gain_shift,
  output logic      [11:0]             ss_threshold,
  output logic      [15:0]             inductor_lin11
);
  import psp_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [15:0] rail_cfg;
    logic [15:0] pg_delay;
    logic [13:0] adv;
    logic [15:0] ind;
    logic        strap_done;
    logic [15:0] rd_data;
    logic        err;
  } psp_top_t;

  psp_top_t    q, d;
  psp_if       pif ();

  logic [39:0] wr_units;
  logic        wr_neg;
  logic        pgd_ok;
  logic        ind_ok;
  logic        hit_rail;
  logic        hit_pgd;
  logic        hit_adv;
  logic        hit_ind;
  logic        mapped;
  logic [39:0] pgd_units;
  logic [15:0] rd_mux;

  // ****************************************************************
  // Decode and validation
  // ****************************************************************
  // Command hits and range checks of the incoming linear-11 word.
  always_comb
  begin
    hit_rail = (cmd_code == CMD_RAIL_CFG);
    hit_pgd  = (cmd_code == CMD_PG_DELAY);
    hit_adv  = (cmd_code == CMD_ADV_LOOP);
    hit_ind  = (cmd_code == CMD_INDUCTOR);
    mapped   = hit_rail || hit_pgd || hit_adv || hit_ind;
    wr_units = psp_lin11_scaled(wr_data);              // [R15]
    wr_neg   = wr_data[LIN_Y_SIGN];                    // [R15]
    pgd_ok   = !wr_neg && (wr_units <= 40'(PG_MAX_UNITS));   // [R10]
    ind_ok   = !wr_neg && (wr_units != 40'h0)
               && (wr_units <= 40'(IND_MAX_UNITS));   // [R14]
  end

  // Read data mux; unused adaptive bits read as zero.
  always_comb
  begin
    rd_mux = 16'h0000;
    case (cmd_code)
      CMD_RAIL_CFG: rd_mux = q.rail_cfg;
      CMD_PG_DELAY: rd_mux = q.pg_delay;
      CMD_ADV_LOOP: rd_mux = {2'b00, q.adv};           // [R13]
      CMD_INDUCTOR: rd_mux = q.ind;
      default:      rd_mux = 16'h0000;
    endcase
  end

  // ****************************************************************
  // Register writes and reads
  // ****************************************************************
  // Accepted writes update a command; rejected ones keep the old value.
  always_comb
  begin
    d     = q;
    d.err = 1'b0;
    if (!q.strap_done)
    begin
      d.strap_done                 = 1'b1;
      d.rail_cfg[RAIL_MSB:RAIL_LSB] = addr_strap[4:0];   // [R5]
    end
    if (wr_en)
    begin
      if (hit_rail)
      begin
        d.rail_cfg                    = '0;
        d.rail_cfg[PH_ID_MSB:PH_ID_LSB] =
          wr_data[PH_ID_MSB:PH_ID_LSB];                 // [R1]
        d.rail_cfg[RAIL_MSB:RAIL_LSB] =
          wr_data[RAIL_MSB:RAIL_LSB];                   // [R2]
        d.rail_cfg[PH_CNT_MSB:PH_CNT_LSB] =
          wr_data[PH_CNT_MSB:PH_CNT_LSB];               // [R3]
      end
      else if (hit_pgd)
      begin
        if (pgd_ok)
          d.pg_delay = wr_data;                         // [R10]
        else
          d.err = 1'b1;                                 // [R10]
      end
      else if (hit_adv)
        d.adv = wr_data[ADV_MSB:0];                     // [R11] [R12]
      else if (hit_ind)
      begin
        if (ind_ok)
          d.ind = wr_data;                              // [R14]
        else
          d.err = 1'b1;
      end
      else
        d.err = 1'b1;
    end
    if (rd_en)
    begin
      d.rd_data = rd_mux;
      if (!mapped)
        d.err = 1'b1;
    end
  end

  // Bank register; rail field is loaded from the strap after release.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q.rail_cfg   <= RAIL_CFG_RST;                     // [R5]
      q.pg_delay   <= PG_DELAY_RST;                     // [R8]
      q.adv        <= ADV_LOOP_RST;                     // [R13]
      q.ind        <= INDUCTOR_RST;                     // [R14]
      q.strap_done <= 1'b0;
      q.rd_data    <= 16'h0000;
      q.err        <= 1'b0;
    end
    else if (ce)
      q <= d;
  end

  // ****************************************************************
  // Helpers and outputs
  // ****************************************************************
  // Stored delay is always in range, so the microsecond count is small.
  assign pgd_units    = psp_lin11_scaled(q.pg_delay);   // [R15]
  assign pif.delay_us = 32'((32'(pgd_units[16:0]) * 32'(US_PER_MS))
                        >> LIN_FRAC);                  // [R8]
  assign pif.out_en   = out_enable;
  assign pif.above_on = vout_above_on;
  assign pif.phase_id  = q.rail_cfg[PH_ID_MSB:PH_ID_LSB];
  assign pif.phases_m1 = q.rail_cfg[PH_CNT_MSB:PH_CNT_LSB];

  psp_pg_timer #(
    .TICK_CYC  (TICK_CYC),
    .MIN_EN_US (MIN_EN_US)
  ) u_pg_timer (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (ce),
    .pif   (pif.tmr)
  );

  psp_phase_gen u_phase_gen (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (ce),
    .pif   (pif.phs)
  );

  // Field outputs from the bank, plus power good from the timer and the offset from the phase generator.
  assign rd_data_q        = q.rd_data;
  assign cmd_err          = q.err;
  assign pgood_pin        = pif.pgood;                  // [R8]
  assign phase_id         = q.rail_cfg[PH_ID_MSB:PH_ID_LSB];
  assign rail_id          = q.rail_cfg[RAIL_MSB:RAIL_LSB];
  assign phase_count      = 4'(q.rail_cfg[PH_CNT_MSB:PH_CNT_LSB])
                            + 4'h1;                    // [R3]
  assign phase_offset_deg = pif.offset_deg;             // [R4]
  assign gain_shift       = q.adv[GAIN_MSB:GAIN_LSB];   // [R11]
  assign ss_threshold     = q.adv[THR_MSB:0];           // [R12]
  assign inductor_lin11   = q.ind;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  strap_rail_a: assert property (ce && !q.strap_done && !wr_en
    |=> rail_id == $past(addr_strap[4:0])) // [R5]
    else $error("Rail field did not take the strap address.");

  phase_wr_a: assert property (ce && wr_en && hit_rail
    |=> phase_id == $past(wr_data[15:13])) // [R1]
    else $error("Phase position not written.");

  rail_wr_a: assert property (ce && wr_en && hit_rail
    |=> rail_id == $past(wr_data[12:8])) // [R2]
    else $error("Rail identifier not written.");

  count_map_a: assert property (ce && wr_en && hit_rail
    |=> phase_count == 4'($past(wr_data[2:0])) + 4'h1) // [R3]
    else $error("Phase count is not field plus one.");

  delay_reject_a: assert property (ce && wr_en && hit_pgd && !pgd_ok
    |=> q.pg_delay == $past(q.pg_delay) && cmd_err) // [R10]
    else $error("Out of range delay was stored.");

  delay_accept_a: assert property (ce && wr_en && hit_pgd && pgd_ok
    |=> q.pg_delay == $past(wr_data) && !cmd_err) // [R10]
    else $error("Valid delay was not stored.");

  gain_wr_a: assert property (ce && wr_en && hit_adv
    |=> gain_shift == $past(wr_data[13:12])
        && ss_threshold == $past(wr_data[11:0])) // [R11]
    else $error("Adaptive loop fields not written.");

  adv_read_a: assert property (ce && rd_en && hit_adv
    |=> rd_data_q[15:14] == 2'b00
        && rd_data_q[13:0] == $past(q.adv)) // [R13]
    else $error("Adaptive loop read shows unused bits.");

  ind_reject_a: assert property (ce && wr_en && hit_ind && !ind_ok
    |=> inductor_lin11 == $past(inductor_lin11)) // [R14]
    else $error("Out of range inductor was stored.");

endmodule // psp_top

// >>> bench/psp_rail_model.sv
// Behavioural output rail outside the config bank.
// Assumes en and ramp_cyc change just after rising edges of mclk.
`timescale 1ns/1ns
module psp_rail_model
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        en,
  input  wire logic [15:0] ramp_cyc,
  output logic             above
);
  // ********
  // Ramp
  // ********
  logic [15:0] cnt_q;

  // The rail passes the threshold ramp_cyc+1 cycles after enable, and
  // collapses on the next clock edge when disabled, as a real output would.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n || !en)
    begin
      cnt_q <= 16'h0000;
      above <= 1'b0;
    end
    else
    begin
      if (cnt_q != 16'hffff)
        cnt_q <= cnt_q + 16'h0001;
      above <= (cnt_q >= ramp_cyc);
    end
  end
endmodule // psp_rail_model

// >>> bench/phase_share_pgood_config_test.sv
// Self-checking bench for the phase share and power good config bank.
// Assumes the package, interface, design and rail model compile first.
`timescale 1ns/1ns
module phase_share_pgood_config_test;
  import psp_pkg::*;

  // ********
  // Signals
  // ********
  localparam int         TK    = 4;
  localparam int         ME    = 5;
  localparam logic [6:0] STRAP = 7'h5b;
  logic        mclk, rst_n, ce, wr_en, rd_en, out_en, above, err, pg, err_s;
  logic        ok;
  logic [7:0]  code, c;
  logic [15:0] wdat, rdat, ramp, d, rd_q, ind, dly_e, ind_e;
  logic [2:0]  pid;
  logic [4:0]  rid;
  logic [3:0]  pcnt;
  logic [8:0]  offs;
  logic [1:0]  gsh;
  logic [11:0] thr;
  logic [31:0] lfsr;
  logic [15:0] corner [10];
  int          errors, compares, n;

  psp_top #(.TICK_CYC(TK), .MIN_EN_US(ME)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .addr_strap(STRAP),
    .cmd_code(code), .wr_en(wr_en), .wr_data(wdat), .rd_en(rd_en),
    .rd_data_q(rd_q), .cmd_err(err), .out_enable(out_en),
    .vout_above_on(above), .pgood_pin(pg), .phase_id(pid),
    .rail_id(rid), .phase_count(pcnt), .phase_offset_deg(offs),
    .gain_shift(gsh), .ss_threshold(thr), .inductor_lin11(ind));

  psp_rail_model rail_u (.mclk(mclk), .rst_n(rst_n), .en(out_en),
    .ramp_cyc(ramp), .above(above));

  // Free-running 100 MHz clock.
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ********
  // Helpers
  // ********
  function automatic logic [31:0] rnd(input logic [31:0] s);
    rnd = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Acceptance of a linear-11 word; negative mantissas never pass.
  function automatic logic lin_ok(input logic [15:0] v, input real mx,
                                  input logic zero_ok);
    real val;
    val = $itor(v[9:0]) * (2.0 ** $itor($signed(v[15:11])));
    lin_ok = !v[10] && val <= mx && (zero_ok || val > 0.0);
  endfunction

  function automatic logic [8:0] exp_off(input int id, input int m1);
    exp_off = 9'((id * (DEG_FULL / (m1 + 1))) % DEG_FULL);
  endfunction

  task automatic draw();
    repeat (16) lfsr = rnd(lfsr);
  endtask

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    if (errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One register access; the strobe stands one cycle, the answer is
  // taken one cycle after the strobe edge.
  task automatic acc(input logic [7:0] cc, input logic w,
                     input logic [15:0] dv);
    @(posedge mclk);
    code  <= cc;
    wdat  <= dv;
    wr_en <= w;
    rd_en <= !w;
    @(posedge mclk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    #1;
    err_s = err;
    rdat  = rd_q;
  endtask

  // Bounded wait for power good or the rail; n counts the cycles.
  task automatic wait_hi(input logic on_pg, input int lim);
    n = 0;
    while ((on_pg ? pg : above) !== 1'b1)
    begin
      @(posedge mclk);
      #1;
      n++;
      if (n > lim)
      begin
        errors++;
        results();
      end
    end
  endtask

  // ********
  // Sequence
  // ********
  initial
  begin
    errors = 0;
    compares = 0;
    lfsr = 32'h208c892a;
    corner = '{16'h007d, 16'h0064, 16'h007e, 16'h0065, 16'h0840,
               16'h0000, 16'h0400, 16'h0464, 16'h0000, 16'hf8c9};
    {ce, wr_en, rd_en, out_en} = 4'h0;
    code = 8'h00;
    wdat = 16'h0000;
    ramp = 16'h0000;
    rst_n = 1'b0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    ce <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk("rail_id", 16'(rid), 16'(STRAP[4:0]));
    chk("phase_count", 16'(pcnt), 16'h0001);
    chk("gain_shift", 16'(gsh), 16'h0002);
    chk("threshold", 16'(thr), 16'h0064);
    chk("pgood", 16'(pg), 16'h0000);
    acc(CMD_RAIL_CFG, 1'b0, 16'h0000);
    chk("rail_cfg", rdat, {3'h0, STRAP[4:0], 8'h00});
    acc(CMD_PG_DELAY, 1'b0, 16'h0000);
    chk("pg_delay", rdat, 16'hba00);
    acc(CMD_ADV_LOOP, 1'b0, 16'h0000);
    chk("adv_loop", rdat, 16'h2064);
    acc(CMD_INDUCTOR, 1'b0, 16'h0000);
    chk("inductor", rdat, 16'haa66);
    // Two-phase rail built in order: same rail, two phases, ids 0 then 1.
    // The group setting lives outside this bank; one rail value is used.
    for (int i = 0; i < 2; i++)
    begin
      acc(CMD_RAIL_CFG, 1'b1, {3'(i), 5'h09, 5'h00, 3'h1});
      @(posedge mclk);
      #1;
      chk("offset", 16'(offs), i ? 16'h00b4 : 16'h0000);
    end
    // Random rail words; the first eight sweep every phase count.
    for (int i = 0; i < 48; i++)
    begin
      draw();
      d = lfsr[15:0];
      if (i < 8)
        d[2:0] = 3'(i);
      acc(CMD_RAIL_CFG, 1'b1, d);
      @(posedge mclk);
      #1;
      chk("phase_id", 16'(pid), 16'(d[15:13]));
      chk("rail_id", 16'(rid), 16'(d[12:8]));
      chk("phase_count", 16'(pcnt), 16'(d[2:0]) + 16'h0001);
      chk("offset", 16'(offs), 16'(exp_off(d[15:13], d[2:0])));
      acc(CMD_RAIL_CFG, 1'b0, 16'h0000);
      chk("rail_cfg", rdat, d & 16'hff07);
    end
    // Every gain code, random thresholds, unused top bits random.
    for (int g = 0; g < 4; g++)
    begin
      draw();
      d = {lfsr[15:14], 2'(g), lfsr[11:0]};
      acc(CMD_ADV_LOOP, 1'b1, d);
      chk("gain_shift", 16'(gsh), 16'(g));
      chk("threshold", 16'(thr), 16'(d[11:0]));
      acc(CMD_ADV_LOOP, 1'b0, 16'h0000);
      chk("adv_loop", rdat, d & 16'h3fff);
    end
    // A write while ce is low must leave the bank frozen.
    @(posedge mclk);
    ce <= 1'b0;
    acc(CMD_ADV_LOOP, 1'b1, 16'h0fff);
    @(posedge mclk);
    ce <= 1'b1;
    acc(CMD_ADV_LOOP, 1'b0, 16'h0000);
    chk("adv_frozen", rdat, d & 16'h3fff);
    // Boundary words first, then random linear-11 words.
    dly_e = 16'hba00;
    ind_e = 16'haa66;
    for (int i = 0; i < 70; i++)
    begin
      draw();
      d = {5'(int'(lfsr[19:16] % 11) - 8), lfsr[10:0]};
      if (i < 10)
        d = corner[i];
      c = i[0] ? CMD_INDUCTOR : CMD_PG_DELAY;
      ok = lin_ok(d, i[0] ? 100.0 : 125.0, !i[0]);
      acc(c, 1'b1, d);
      chk("cmd_err", 16'(err_s), 16'(!ok));
      if (ok && i[0])
        ind_e = d;
      if (ok && !i[0])
        dly_e = d;
      acc(c, 1'b0, 16'h0000);
      chk("lin11_word", rdat, i[0] ? ind_e : dly_e);
      chk("inductor", ind, ind_e);
    end
    // Unmapped codes are refused on write and on read.
    acc(8'hd7, 1'b1, 16'h1234);
    chk("cmd_err", 16'(err_s), 16'h0001);
    acc(8'hd2, 1'b0, 16'h0000);
    chk("cmd_err", 16'(err_s), 16'h0001);
    // Zero delay: power good still waits out the minimum enabled time.
    acc(CMD_PG_DELAY, 1'b1, 16'h0000);
    @(posedge mclk);
    out_en <= 1'b1;
    wait_hi(1'b1, 200);
    chk("pg_min_low", 16'(n >= (ME - 1) * TK), 16'h0001);
    chk("pg_min_hi", 16'(n <= (ME + 1) * TK + 3), 16'h0001);
    @(posedge mclk);
    out_en <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    chk("pgood", 16'(pg), 16'h0000);
    // A quarter millisecond delay after a slow rail ramp.
    acc(CMD_PG_DELAY, 1'b1, 16'hd010);
    @(posedge mclk);
    ramp <= 16'h001e;
    out_en <= 1'b1;
    wait_hi(1'b0, 100);
    wait_hi(1'b1, 1200);
    chk("pg_early", 16'(n >= 249 * TK), 16'h0001);
    chk("pg_late", 16'(n <= 251 * TK + 3), 16'h0001);
    results();
  end
endmodule // phase_share_pgood_config_test
